/* src/aoc_pkg.sv */
// Constants shared by the alarm output controller and its record store
// Overview of operation
// RQ1: Four alarm lines, each channel assignable
// RQ2: Alarm only on failing reading during scan
// RQ3: Shared line is OR of channel alarms
// RQ4: Alarm event moves line toward active level
// RQ5: Latch mode holds active level after event
// RQ6: Latch released by scan, reset, clear
// RQ7: Latch mode scan start erases records
// RQ8: Track mode active while reading beyond limit
// RQ9: Track mode releases on passing reading
// RQ10: Track mode scan start clears line, records
// RQ11: Manual clear forces line inactive, keeps records
// RQ12: Per-line polarity selects active high or low
// RQ13: Default mapping puts channels on line one
// RQ14: Add command maps channel to selected line
// RQ15: Delete command unmaps channel from selected line
// RQ16: Status shows unlisted, passing or alarmed live
// RQ17: Alarmed channel returns to passing on pass
// RQ18: Reset leaves lines inactive, records empty
// RQ19: Keep first hundred events of last scan
package aoc_pkg;
  localparam int NUM_CH = 16;
  localparam int CH_W = 4;
  localparam int NUM_LINE = 4;
  localparam int LINE_W = 2;
  localparam int REC_DEPTH = 100;
  localparam int REC_IDX_W = 7;
  localparam int READ_W = 16;
  localparam int TIME_W = 32;
  localparam int ST_W = 2;
  localparam logic [LINE_W-1:0] LINE_DEFAULT = 2'h0;
  localparam logic [REC_IDX_W-1:0] REC_FULL = 7'h64;
  localparam logic [REC_IDX_W-1:0] REC_ONE = 7'h01;
  localparam logic [REC_IDX_W-1:0] REC_EMPTY = 7'h00;
  localparam logic [ST_W-1:0] ST_NOT_LISTED = 2'h0;
  localparam logic [ST_W-1:0] ST_PASS = 2'h1;
  localparam logic [ST_W-1:0] ST_ALARM = 2'h2;
  localparam logic MODE_TRACK = 1'b0;
  localparam logic MODE_LATCH = 1'b1;
endpackage

/* src/aoc_rec_store.sv */
// Alarm record store holding the first events of the current scan
`timescale 1ns/1ps
`default_nettype none
module aoc_rec_store
  import aoc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [READ_W-1:0] wr_reading_i,
  input wire logic [TIME_W-1:0] wr_time_i,
  input wire logic [CH_W-1:0] wr_ch_i,
  input wire logic wr_mode_i,
  input wire logic [REC_IDX_W-1:0] rd_idx_i,
  output logic [REC_IDX_W-1:0] count_o,
  output logic [READ_W-1:0] rd_reading_o,
  output logic [TIME_W-1:0] rd_time_o,
  output logic [CH_W-1:0] rd_ch_o,
  output logic rd_mode_o
);
  logic [READ_W-1:0] reading_mem [REC_DEPTH];
  logic [TIME_W-1:0] time_mem [REC_DEPTH];
  logic [CH_W-1:0] ch_mem [REC_DEPTH];
  logic mode_mem [REC_DEPTH];
  logic [REC_IDX_W-1:0] count_r;
  logic take;

  // Later events are dropped once full, so the oldest history survives
  assign take = wr_i && (count_r < REC_FULL); // see RQ19

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      count_r <= REC_EMPTY; // see RQ18
    end
    else if (clear_i)
    begin
      count_r <= REC_EMPTY; // see RQ7 see RQ10
    end
    else if (take)
    begin
      count_r <= count_r + REC_ONE;
    end
  end

  // Data needs no reset; entries at or past the count read as zero
  always_ff @(posedge clock_i)
  begin
    if (take && !clear_i)
    begin
      reading_mem[count_r] <= wr_reading_i;
      time_mem[count_r] <= wr_time_i;
      ch_mem[count_r] <= wr_ch_i;
      mode_mem[count_r] <= wr_mode_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i || rd_idx_i >= count_r)
    begin
      rd_reading_o <= '0;
      rd_time_o <= '0;
      rd_ch_o <= '0;
      rd_mode_o <= 1'b0;
    end
    else
    begin
      rd_reading_o <= reading_mem[rd_idx_i];
      rd_time_o <= time_mem[rd_idx_i];
      rd_ch_o <= ch_mem[rd_idx_i];
      rd_mode_o <= mode_mem[rd_idx_i];
    end
  end

  assign count_o = count_r;

  a_count_bound: assert property (@(posedge clock_i) disable iff (rst_i)
    count_r <= REC_FULL) else $error("record count above capacity"); // see RQ19
  a_count_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    clear_i |=> count_r == REC_EMPTY) else $error("scan start kept records"); // see RQ7
  a_count_grow: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_i && !clear_i && count_r < REC_FULL) |=>
      count_r == $past(count_r) + REC_ONE)
    else $error("event not recorded"); // see RQ19
endmodule
`default_nettype wire

/* src/aoc_top.sv */
// Alarm output controller: channel mapping, line state, status and records
`timescale 1ns/1ps
`default_nettype none
module aoc_top
  import aoc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic scan_active_i,
  input wire logic scan_start_i,
  input wire logic result_valid_i,
  input wire logic result_fail_i,
  input wire logic [CH_W-1:0] result_ch_i,
  input wire logic [READ_W-1:0] result_reading_i,
  input wire logic [TIME_W-1:0] time_i,
  input wire logic [NUM_CH-1:0] in_scan_list_i,
  input wire logic [NUM_LINE-1:0] latch_mode_i,
  input wire logic [NUM_LINE-1:0] active_high_i,
  input wire logic [LINE_W-1:0] sel_line_i,
  input wire logic add_cmd_i,
  input wire logic del_cmd_i,
  input wire logic [CH_W-1:0] cmd_ch_i,
  input wire logic clear_cmd_i,
  input wire logic [REC_IDX_W-1:0] rec_idx_i,
  output logic alarm_line_one_o,
  output logic alarm_line_two_o,
  output logic alarm_line_three_o,
  output logic alarm_line_four_o,
  output logic [NUM_CH*ST_W-1:0] chan_status_o,
  output logic [REC_IDX_W-1:0] rec_count_o,
  output logic [READ_W-1:0] rec_reading_o,
  output logic [TIME_W-1:0] rec_time_o,
  output logic [CH_W-1:0] rec_ch_o,
  output logic rec_mode_o
);
  // Pin level for a given alarm state and polarity
  function automatic logic pin_level(input logic act, input logic high);
    pin_level = high ? act : !act; // see RQ12
  endfunction

  // Channel drives a line only while mapped and assigned to it
  function automatic logic drives(input logic vld, input logic [LINE_W-1:0] ln,
                                  input int l);
    drives = vld && (ln == l[LINE_W-1:0]);
  endfunction

  logic [LINE_W-1:0] map_line_r [NUM_CH];
  logic [NUM_CH-1:0] map_vld_r;
  logic [NUM_CH-1:0] alarmed_r;
  logic [NUM_CH-1:0] alarmed_nxt;
  logic [NUM_LINE-1:0] active_r;
  logic [NUM_LINE-1:0] active_nxt;
  logic [NUM_LINE-1:0] pin_r;
  logic [NUM_LINE-1:0] pin_nxt;
  logic [NUM_LINE-1:0] line_ev;
  logic [NUM_LINE-1:0] line_pass;
  logic [NUM_LINE-1:0] line_busy;
  logic [NUM_CH*ST_W-1:0] status_r;
  logic [NUM_CH*ST_W-1:0] status_nxt;
  logic res_ok;
  logic fail_ev;
  logic pass_ev;
  logic ev_mode;

  // Results outside a scan are ignored entirely
  assign res_ok = result_valid_i && scan_active_i; // see RQ2
  assign fail_ev = res_ok && result_fail_i && map_vld_r[result_ch_i]; // see RQ2
  assign pass_ev = res_ok && !result_fail_i;
  assign ev_mode = latch_mode_i[map_line_r[result_ch_i]];

  // Mapping; add wins if add and delete arrive together
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      map_vld_r <= '1;
      for (int c = 0; c < NUM_CH; c++)
      begin
        map_line_r[c] <= LINE_DEFAULT; // see RQ13
      end
    end
    else if (add_cmd_i)
    begin
      map_line_r[cmd_ch_i] <= sel_line_i; // see RQ14 see RQ1
      map_vld_r[cmd_ch_i] <= 1'b1;
    end
    else if (del_cmd_i && map_line_r[cmd_ch_i] == sel_line_i)
    begin
      map_vld_r[cmd_ch_i] <= 1'b0; // see RQ15
    end
  end

  // Per-channel alarm flag: set by a failing reading, cleared by a pass
  always_comb
  begin
    alarmed_nxt = alarmed_r;
    if (scan_start_i)
    begin
      alarmed_nxt = '0;
    end
    if (pass_ev)
    begin
      alarmed_nxt[result_ch_i] = 1'b0; // see RQ17
    end
    if (res_ok && result_fail_i)
    begin
      alarmed_nxt[result_ch_i] = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      alarmed_r <= '0;
    end
    else
    begin
      alarmed_r <= alarmed_nxt;
    end
  end

  // Per-line event, pass and still-alarmed terms
  always_comb
  begin
    line_ev = '0;
    line_pass = '0;
    line_busy = '0;
    for (int l = 0; l < NUM_LINE; l++)
    begin
      line_ev[l] = fail_ev &&
        drives(1'b1, map_line_r[result_ch_i], l); // see RQ3
      line_pass[l] = pass_ev &&
        drives(map_vld_r[result_ch_i], map_line_r[result_ch_i], l);
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (alarmed_nxt[c] && drives(map_vld_r[c], map_line_r[c], l))
        begin
          line_busy[l] = 1'b1; // see RQ3
        end
      end
    end
  end

  // Line state; a fresh event beats any clear in the same cycle
  always_comb
  begin
    active_nxt = active_r;
    for (int l = 0; l < NUM_LINE; l++)
    begin
      if (scan_start_i)
      begin
        active_nxt[l] = 1'b0; // see RQ6 see RQ10
      end
      else if (clear_cmd_i && sel_line_i == l[LINE_W-1:0])
      begin
        active_nxt[l] = 1'b0; // see RQ11
      end
      else if (latch_mode_i[l] == MODE_TRACK && line_pass[l] && !line_busy[l])
      begin
        active_nxt[l] = 1'b0; // see RQ9
      end
      if (line_ev[l])
      begin
        active_nxt[l] = 1'b1; // see RQ4 see RQ5 see RQ8
      end
    end
  end

  always_comb
  begin
    pin_nxt = '0;
    for (int l = 0; l < NUM_LINE; l++)
    begin
      pin_nxt[l] = pin_level(active_nxt[l], active_high_i[l]); // see RQ12
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      active_r <= '0; // see RQ18
      for (int l = 0; l < NUM_LINE; l++)
      begin
        pin_r[l] <= pin_level(1'b0, active_high_i[l]); // see RQ18
      end
    end
    else
    begin
      active_r <= active_nxt;
      pin_r <= pin_nxt;
    end
  end

  // Status is taken from the next flags so it is current, not a cycle late
  always_comb
  begin
    status_nxt = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (!in_scan_list_i[c])
      begin
        status_nxt[c*ST_W +: ST_W] = ST_NOT_LISTED; // see RQ16
      end
      else if (alarmed_nxt[c])
      begin
        status_nxt[c*ST_W +: ST_W] = ST_ALARM; // see RQ16
      end
      else
      begin
        status_nxt[c*ST_W +: ST_W] = ST_PASS; // see RQ17
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  // Records survive manual clear; only scan start or reset empties them
  aoc_rec_store u_store (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(scan_start_i), // see RQ7 see RQ10 see RQ11
    .wr_i(fail_ev),
    .wr_reading_i(result_reading_i),
    .wr_time_i(time_i),
    .wr_ch_i(result_ch_i),
    .wr_mode_i(ev_mode),
    .rd_idx_i(rec_idx_i),
    .count_o(rec_count_o),
    .rd_reading_o(rec_reading_o),
    .rd_time_o(rec_time_o),
    .rd_ch_o(rec_ch_o),
    .rd_mode_o(rec_mode_o)
  );

  assign alarm_line_one_o = pin_r[0];
  assign alarm_line_two_o = pin_r[1];
  assign alarm_line_three_o = pin_r[2];
  assign alarm_line_four_o = pin_r[3];
  assign chan_status_o = status_r;

  a_event_drives_pin: assert property (@(posedge clock_i) disable iff (rst_i)
    line_ev[0] |=> (alarm_line_one_o == $past(active_high_i[0])))
    else $error("alarm event did not drive line one active"); // see RQ4
  a_latch_holds: assert property (@(posedge clock_i) disable iff (rst_i)
    (active_r[1] && latch_mode_i[1] && !scan_start_i &&
     !(clear_cmd_i && sel_line_i == 2'h1)) |=> active_r[1])
    else $error("latched line released"); // see RQ5
  // A failing result in the start cycle re-arms its flag, so it is excluded
  a_scan_releases: assert property (@(posedge clock_i) disable iff (rst_i)
    (scan_start_i && !(res_ok && result_fail_i)) |=>
      (active_r == '0 && alarmed_r == '0))
    else $error("scan start left alarm state"); // see RQ6
  a_manual_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    (clear_cmd_i && !scan_start_i && !line_ev[sel_line_i]) |=>
      (!active_r[$past(sel_line_i)] && rec_count_o == $past(rec_count_o) +
       {{(REC_IDX_W-1){1'b0}}, $past(fail_ev && rec_count_o < REC_FULL)}))
    else $error("manual clear failed or touched records"); // see RQ11
  a_track_release: assert property (@(posedge clock_i) disable iff (rst_i)
    (latch_mode_i[0] == MODE_TRACK && line_pass[0] && !line_busy[0] &&
     !line_ev[0]) |=> !active_r[0])
    else $error("track line not released on pass"); // see RQ9
  a_line_four_event: assert property (@(posedge clock_i) disable iff (rst_i)
    line_ev[3] |=> (alarm_line_four_o == $past(active_high_i[3])))
    else $error("alarm event did not drive line four active"); // see RQ1
  a_status_alarm: assert property (@(posedge clock_i) disable iff (rst_i)
    (res_ok && result_fail_i && in_scan_list_i[result_ch_i]) |=>
      chan_status_o[$past(result_ch_i)*ST_W +: ST_W] == ST_ALARM)
    else $error("failing channel not shown alarmed"); // see RQ16
  a_reset_inactive: assert property (@(posedge clock_i)
    rst_i |=> (active_r == '0 && rec_count_o == REC_EMPTY))
    else $error("reset left a line active or records kept"); // see RQ18
  a_pass_status: assert property (@(posedge clock_i) disable iff (rst_i)
    (pass_ev && in_scan_list_i[result_ch_i] && !scan_start_i) |=>
      chan_status_o[$past(result_ch_i)*ST_W +: ST_W] == ST_PASS)
    else $error("passing channel not shown passing"); // see RQ17
  a_default_map: assert property (@(posedge clock_i)
    rst_i |=> (map_vld_r == '1 && map_line_r[0] == LINE_DEFAULT &&
               map_line_r[NUM_CH-1] == LINE_DEFAULT))
    else $error("default mapping wrong"); // see RQ13
  a_delete_unmaps: assert property (@(posedge clock_i) disable iff (rst_i)
    (del_cmd_i && !add_cmd_i && map_line_r[cmd_ch_i] == sel_line_i) |=>
      !map_vld_r[$past(cmd_ch_i)])
    else $error("deleted channel still mapped"); // see RQ15
  a_add_maps: assert property (@(posedge clock_i) disable iff (rst_i)
    add_cmd_i |=> (map_vld_r[$past(cmd_ch_i)] &&
                   map_line_r[$past(cmd_ch_i)] == $past(sel_line_i)))
    else $error("added channel not mapped"); // see RQ14
  a_no_scan_no_event: assert property (@(posedge clock_i) disable iff (rst_i)
    !scan_active_i |-> line_ev == '0)
    else $error("event raised outside a scan"); // see RQ2
endmodule
`default_nettype wire

/* verif/aoc_pin_watch.sv */
// External monitor counting clock edges at which any of the four alarm pins changed
`timescale 1ns/1ps
`default_nettype none
module aoc_pin_watch
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] pins_i,
  output logic [7:0] edges_o
);
  logic [3:0] last_r;
  // A pin that stays static on an event leaves the count unchanged
  always_ff @(posedge clock_i)
  begin
    last_r <= pins_i;
    if (rst_i)
      edges_o <= 8'h00;
    else if (pins_i != last_r)
      edges_o <= edges_o + 8'h01;
  end
endmodule
`default_nettype wire

/* verif/alarm_output_controller_test.sv */
// Self-checking bench for the alarm output controller
`timescale 1ns/1ps
`default_nettype none
module alarm_output_controller_test;
  import aoc_pkg::*;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic scan_act = 1'h0;
  logic [3:0] pulse = 4'h0;
  logic valid = 1'h0;
  logic fail = 1'h0;
  logic [3:0] rch = 4'h0;
  logic [3:0] cch = 4'h0;
  logic [15:0] rd = 16'h0000;
  logic [31:0] tm = 32'h0000_0000;
  logic [15:0] listed = 16'hFDFF;
  logic [3:0] latch = 4'h0;
  logic [3:0] ahigh = 4'hD;
  logic [1:0] sel = 2'h0;
  logic [6:0] ridx = 7'h00;
  logic [3:0] pins;
  logic [31:0] stat;
  logic [6:0] cnt;
  logic [15:0] rrd;
  logic [31:0] rtm;
  logic [3:0] rchan;
  logic rmode;
  logic [7:0] edges;
  int err_total = 0;
  int tests_run = 0;

  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i)
    tm <= tm + 32'h0000_0001;

  aoc_top u_aoc_top (.clock_i(clock_i), .rst_i(rst_i),
    .scan_active_i(scan_act), .scan_start_i(pulse[3]),
    .result_valid_i(valid), .result_fail_i(fail), .result_ch_i(rch),
    .result_reading_i(rd), .time_i(tm), .in_scan_list_i(listed),
    .latch_mode_i(latch), .active_high_i(ahigh), .sel_line_i(sel),
    .add_cmd_i(pulse[2]), .del_cmd_i(pulse[1]), .cmd_ch_i(cch),
    .clear_cmd_i(pulse[0]), .rec_idx_i(ridx),
    .alarm_line_one_o(pins[0]), .alarm_line_two_o(pins[1]),
    .alarm_line_three_o(pins[2]), .alarm_line_four_o(pins[3]),
    .chan_status_o(stat), .rec_count_o(cnt), .rec_reading_o(rrd),
    .rec_time_o(rtm), .rec_ch_o(rchan), .rec_mode_o(rmode));

  aoc_pin_watch u_aoc_pin_watch (.clock_i(clock_i), .rst_i(rst_i),
    .pins_i(pins), .edges_o(edges));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One judged reading, then time for line, status and record to land
  task automatic res(input logic f, input logic [3:0] c);
    @(posedge clock_i);
    valid <= 1'h1;
    fail <= f;
    rch <= c;
    @(posedge clock_i);
    valid <= 1'h0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  // Pulse bits: scan start, add, delete, clear
  task automatic cmd(input logic [3:0] k, input logic [3:0] c,
                     input logic [1:0] s);
    @(posedge clock_i);
    pulse <= k;
    cch <= c;
    sel <= s;
    @(posedge clock_i);
    pulse <= 4'h0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  task automatic t_reset;
    chk(pins, 4'h2);
    chk(cnt, 7'h00);
    res(1'h1, 4'h3);
    chk(pins, 4'h2);
    chk(cnt, 7'h00);
  endtask

  task automatic t_track;
    logic [7:0] e0;
    @(posedge clock_i);
    scan_act <= 1'h1;
    e0 = edges;
    res(1'h1, 4'h3);
    chk(pins, 4'h3);
    chk(stat[7:6], ST_ALARM);
    chk(cnt, 7'h01);
    chk(edges, e0 + 8'h01);
    chk(stat[19:18], ST_NOT_LISTED);
    res(1'h1, 4'h3);
    chk(pins, 4'h3);
    res(1'h0, 4'h3);
    chk(pins, 4'h2);
    chk(stat[7:6], ST_PASS);
  endtask

  task automatic t_or;
    res(1'h1, 4'h3);
    res(1'h1, 4'h4);
    res(1'h0, 4'h3);
    chk(pins, 4'h3);
    res(1'h0, 4'h4);
    chk(pins, 4'h2);
    cmd(4'h2, 4'h4, 2'h0);
    res(1'h1, 4'h4);
    chk(pins, 4'h2);
  endtask

  task automatic t_latch;
    logic [6:0] n;
    @(posedge clock_i);
    latch <= 4'h2;
    ridx <= 7'h04;
    cmd(4'h4, 4'h5, 2'h1);
    res(1'h1, 4'h5);
    chk(pins, 4'h0);
    chk(rmode, MODE_LATCH);
    chk(rchan, 4'h5);
    res(1'h0, 4'h5);
    chk(pins, 4'h0);
    n = cnt;
    cmd(4'h1, 4'h0, 2'h1);
    chk(pins, 4'h2);
    chk(cnt, n);
    res(1'h1, 4'h5);
    res(1'h1, 4'h3);
    chk(pins, 4'h1);
    cmd(4'h4, 4'h6, 2'h3);
    res(1'h1, 4'h6);
    chk(pins, 4'h9);
    cmd(4'h8, 4'h0, 2'h0);
    chk(pins, 4'h2);
    chk(cnt, 7'h00);
  endtask

  task automatic t_full;
    logic [31:0] t0;
    @(posedge clock_i);
    // The stamp seen at the next edge is one count past this one
    t0 = tm;
    valid <= 1'h1;
    fail <= 1'h1;
    rch <= 4'h7;
    rd <= 16'h00A5;
    repeat (101) @(posedge clock_i);
    valid <= 1'h0;
    ridx <= 7'h00;
    repeat (3) @(posedge clock_i);
    #1;
    chk(cnt, REC_FULL);
    chk(rchan, 4'h7);
    chk(rrd, 16'h00A5);
    chk(rtm, t0 + 32'h0000_0001);
    chk(rmode, MODE_TRACK);
    @(posedge clock_i);
    ridx <= 7'h64;
    repeat (2) @(posedge clock_i);
    #1;
    chk(rrd, 16'h0000);
    cmd(4'h8, 4'h0, 2'h0);
    chk(cnt, 7'h00);
  endtask

  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'h0;
    @(posedge clock_i);
    #1;
    t_reset();
    t_track();
    t_or();
    t_latch();
    t_full();
    conclude();
  end

  // The sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
